// file: dasb_map.vh
// address map, field positions and reset values of the dual converter register bank
// assumes: included by the bank module only; byte-wide special-function register bus
`ifndef DASB_MAP_VH
`define DASB_MAP_VH

`define DASB_A_MODE      8'hD1
`define DASB_A_PCTL      8'hD2
`define DASB_A_ACTL      8'hD3
`define DASB_A_SINC      8'hD4
`define DASB_A_EXC       8'hD5
`define DASB_A_STAT      8'hD8
`define DASB_A_PRES_M    8'hDA
`define DASB_A_PRES_H    8'hDB
`define DASB_A_ARES_L    8'hDC
`define DASB_A_ARES_H    8'hDD
`define DASB_A_POFS_M    8'hE2
`define DASB_A_POFS_H    8'hE3
`define DASB_A_AOFS_L    8'hE4
`define DASB_A_AOFS_H    8'hE5
`define DASB_A_PGN_M     8'hEA
`define DASB_A_PGN_H     8'hEB
`define DASB_A_AGN_L     8'hEC
`define DASB_A_AGN_H     8'hED

`define DASB_STAT_BASE   5'h1B
`define DASB_UNDEF_VAL   8'hFF

`define DASB_RST_ZERO    8'h00
`define DASB_RST_SINC    8'h45
`define DASB_RST_OFS_LO  8'h00
`define DASB_RST_OFS_HI  8'h80
`define DASB_RST_PGN_M   8'h55
`define DASB_RST_PGN_H   8'h53
`define DASB_RST_AGN_L   8'h9A
`define DASB_RST_AGN_H   8'h59
`define DASB_ONES16      16'hFFFF

`define DASB_ST_PRDY     3'h7
`define DASB_ST_ARDY     3'h6
`define DASB_ST_CAL      3'h5
`define DASB_ST_NOREF    3'h4
`define DASB_ST_PERR     3'h3
`define DASB_ST_AERR     3'h2

`define DASB_MD_LSB      0
`define DASB_MD_MSB      2
`define DASB_MD_IDLE     3'h0
`define DASB_MD_PEN      5
`define DASB_MD_AEN      4
`define DASB_CTL_EXTREF  6

`define DASB_KIND_CONV   2'h0
`define DASB_KIND_OFS    2'h1
`define DASB_KIND_GAIN   2'h2

`endif

// file: dasb_bank.v
// register bank controlling a primary and an auxiliary sigma-delta converter
// assumes: core drives byte and bit accesses synchronous to clk_i, one access per cycle;
// converter engines report completion as one-cycle pulses with data and kind alongside
`timescale 1ns/10ps
`default_nettype none
`include "dasb_map.vh"

module dasb_bank (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_b_i,
  // byte access from the core
  input  wire [7:0]  sfr_addr_i,
  input  wire        sfr_wr_i,
  input  wire        sfr_rd_i,
  input  wire [7:0]  sfr_wdata_i,
  output reg  [7:0]  sfr_rdata_o,
  output reg         sfr_hit_o,
  // single-bit access from the core
  input  wire [7:0]  bit_addr_i,
  input  wire        bit_wr_i,
  input  wire        bit_rd_i,
  input  wire        bit_wdata_i,
  output reg         bit_rdata_o,
  output reg         bit_hit_o,
  // primary converter engine
  input  wire        pri_done_i,
  input  wire [1:0]  pri_kind_i,
  input  wire [15:0] pri_data_i,
  input  wire        pri_clamp_i,
  // auxiliary converter engine
  input  wire        aux_done_i,
  input  wire [1:0]  aux_kind_i,
  input  wire [15:0] aux_data_i,
  input  wire        aux_clamp_i,
  // reference detector
  input  wire        ref_missing_i,
  // configuration towards the converters
  output wire [7:0]  converter_mode_o,
  output wire [7:0]  pri_control_o,
  output wire [7:0]  aux_control_o,
  output wire [7:0]  sinc_decimation_o,
  output wire [7:0]  excitation_o,
  output wire        start_pulse_o
);

  // converter register file, index 0 primary, 1 auxiliary
  reg  [7:0]  mode_ff;
  reg  [7:0]  ctl_ff   [0:1];
  reg  [7:0]  sinc_ff;
  reg  [7:0]  exc_ff;
  reg  [15:0] res_ff   [0:1];
  reg  [15:0] ofs_ff   [0:1];
  reg  [15:0] gain_ff  [0:1];
  reg  [1:0]  rdy_ff;
  reg  [1:0]  err_ff;
  reg         cal_ff;
  reg         start_ff;

  wire [7:0]  stat_w;
  wire        any_active_w;
  wire        noref_w;
  wire        mode_wr_w;
  wire        mode_start_w;
  wire [1:0]  done_w;
  wire [1:0]  accept_w;
  wire [1:0]  rdy_clr_w;
  wire [1:0]  rdy_wset_w;
  wire        cal_done_w;
  reg  [7:0]  rd_mux;
  reg         rd_hit;

  // decode of byte addresses, used by the write paths; the read mux decodes with its own case
  function is_addr;
    input [7:0] a;
    input [7:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  // hit flag for a bit address inside the status byte
  function stat_bit_hit;
    input [7:0] a;
    begin
      stat_bit_hit = (a[7:3] == `DASB_STAT_BASE);
    end
  endfunction

  assign any_active_w = mode_ff[`DASB_MD_PEN] | mode_ff[`DASB_MD_AEN];
  assign noref_w      = ref_missing_i & any_active_w;
  assign stat_w       = {rdy_ff[0], rdy_ff[1], cal_ff, noref_w,
                         err_ff[0], err_ff[1], 2'b00};

  assign mode_wr_w    = sfr_wr_i & is_addr(sfr_addr_i, `DASB_A_MODE);
  assign mode_start_w = mode_wr_w & (sfr_wdata_i[`DASB_MD_MSB:`DASB_MD_LSB] != `DASB_MD_IDLE);
  assign done_w       = {aux_done_i, pri_done_i};
  assign cal_done_w   = (pri_done_i & accept_w[0] & (pri_kind_i != `DASB_KIND_CONV)) |
                        (aux_done_i & accept_w[1] & (aux_kind_i != `DASB_KIND_CONV));

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_conv
      localparam [2:0] RDY_BIT = (g == 0) ? `DASB_ST_PRDY : `DASB_ST_ARDY;
      wire [1:0]  kind_w  = (g == 0) ? pri_kind_i  : aux_kind_i;
      wire [15:0] data_w  = (g == 0) ? pri_data_i  : aux_data_i;
      wire        clamp_w = (g == 0) ? pri_clamp_i : aux_clamp_i;
      // external reference missing forces the result to full scale
      wire        force_w = ref_missing_i & ctl_ff[g][`DASB_CTL_EXTREF];
      wire        stat_bw = bit_wr_i & (bit_addr_i == {`DASB_STAT_BASE, RDY_BIT});
      wire        stat_yw = sfr_wr_i & is_addr(sfr_addr_i, `DASB_A_STAT);
      wire        nxt_wv  = stat_yw ? sfr_wdata_i[RDY_BIT] : bit_wdata_i;

      // software clears directly, or indirectly through a start write
      assign rdy_clr_w[g]  = mode_start_w | ((stat_bw | stat_yw) & ~nxt_wv);
      assign rdy_wset_w[g] = (stat_bw | stat_yw) & nxt_wv;
      // results held until ready clears; a clear in the same cycle lets new data in
      assign accept_w[g]   = done_w[g] & (~rdy_ff[g] | rdy_clr_w[g]);

      always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          rdy_ff[g] <= 1'b0;
          err_ff[g] <= 1'b0;
          res_ff[g] <= 16'h0000;
        end else begin
          // set wins over any clear in the same cycle
          if (accept_w[g] | rdy_wset_w[g])
            rdy_ff[g] <= 1'b1;
          else if (rdy_clr_w[g])
            rdy_ff[g] <= 1'b0;
          if (accept_w[g] & (clamp_w | force_w))
            err_ff[g] <= 1'b1;
          else if (mode_start_w)
            err_ff[g] <= 1'b0;
          if (accept_w[g] & (kind_w == `DASB_KIND_CONV))
            res_ff[g] <= force_w ? `DASB_ONES16 : data_w;
        end
      end

      // coefficients: factory values at power-up, core writes, calibration updates
      always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          ofs_ff[g]  <= {`DASB_RST_OFS_HI, `DASB_RST_OFS_LO};
          gain_ff[g] <= (g == 0) ? {`DASB_RST_PGN_H, `DASB_RST_PGN_M}
                                 : {`DASB_RST_AGN_H, `DASB_RST_AGN_L};
        end else begin
          if (accept_w[g] & (kind_w == `DASB_KIND_OFS) & ~clamp_w)
            ofs_ff[g] <= data_w;
          else if (sfr_wr_i & is_addr(sfr_addr_i, (g == 0) ? `DASB_A_POFS_M : `DASB_A_AOFS_L))
            ofs_ff[g][7:0] <= sfr_wdata_i;
          else if (sfr_wr_i & is_addr(sfr_addr_i, (g == 0) ? `DASB_A_POFS_H : `DASB_A_AOFS_H))
            ofs_ff[g][15:8] <= sfr_wdata_i;
          if (accept_w[g] & (kind_w == `DASB_KIND_GAIN) & ~clamp_w)
            gain_ff[g] <= data_w;
          else if (sfr_wr_i & is_addr(sfr_addr_i, (g == 0) ? `DASB_A_PGN_M : `DASB_A_AGN_L))
            gain_ff[g][7:0] <= sfr_wdata_i;
          else if (sfr_wr_i & is_addr(sfr_addr_i, (g == 0) ? `DASB_A_PGN_H : `DASB_A_AGN_H))
            gain_ff[g][15:8] <= sfr_wdata_i;
        end
      end

      always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i)
          ctl_ff[g] <= `DASB_RST_ZERO;
        else if (sfr_wr_i & is_addr(sfr_addr_i, (g == 0) ? `DASB_A_PCTL : `DASB_A_ACTL))
          ctl_ff[g] <= sfr_wdata_i;
      end
    end
  endgenerate

  // shared configuration; any other address falls through untouched
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_ff  <= `DASB_RST_ZERO;
      sinc_ff  <= `DASB_RST_SINC;
      exc_ff   <= `DASB_RST_ZERO;
      cal_ff   <= 1'b0;
      start_ff <= 1'b0;
    end else begin
      start_ff <= mode_start_w;
      if (mode_wr_w)
        mode_ff <= sfr_wdata_i;
      if (sfr_wr_i & is_addr(sfr_addr_i, `DASB_A_SINC))
        sinc_ff <= sfr_wdata_i;
      if (sfr_wr_i & is_addr(sfr_addr_i, `DASB_A_EXC))
        exc_ff <= sfr_wdata_i;
      if (cal_done_w)
        cal_ff <= 1'b1;
      else if (mode_start_w)
        cal_ff <= 1'b0;
    end
  end

  // byte read mux; unmapped addresses report no hit and an undefined byte
  always @* begin
    rd_hit = 1'b1;
    case (sfr_addr_i)
      `DASB_A_MODE:   rd_mux = mode_ff;
      `DASB_A_PCTL:   rd_mux = ctl_ff[0];
      `DASB_A_ACTL:   rd_mux = ctl_ff[1];
      `DASB_A_SINC:   rd_mux = sinc_ff;
      `DASB_A_EXC:    rd_mux = exc_ff;
      `DASB_A_STAT:   rd_mux = stat_w;
      `DASB_A_PRES_M: rd_mux = res_ff[0][7:0];
      `DASB_A_PRES_H: rd_mux = res_ff[0][15:8];
      `DASB_A_ARES_L: rd_mux = res_ff[1][7:0];
      `DASB_A_ARES_H: rd_mux = res_ff[1][15:8];
      `DASB_A_POFS_M: rd_mux = ofs_ff[0][7:0];
      `DASB_A_POFS_H: rd_mux = ofs_ff[0][15:8];
      `DASB_A_AOFS_L: rd_mux = ofs_ff[1][7:0];
      `DASB_A_AOFS_H: rd_mux = ofs_ff[1][15:8];
      `DASB_A_PGN_M:  rd_mux = gain_ff[0][7:0];
      `DASB_A_PGN_H:  rd_mux = gain_ff[0][15:8];
      `DASB_A_AGN_L:  rd_mux = gain_ff[1][7:0];
      `DASB_A_AGN_H:  rd_mux = gain_ff[1][15:8];
      default: begin
        rd_mux = `DASB_UNDEF_VAL;
        rd_hit = 1'b0;
      end
    endcase
  end

  // read data registered so the core samples a stable value one cycle later
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sfr_rdata_o <= `DASB_RST_ZERO;
      sfr_hit_o   <= 1'b0;
      bit_rdata_o <= 1'b0;
      bit_hit_o   <= 1'b0;
    end else begin
      if (sfr_rd_i) begin
        sfr_rdata_o <= rd_mux;
        sfr_hit_o   <= rd_hit;
      end
      if (bit_rd_i) begin
        bit_rdata_o <= stat_bit_hit(bit_addr_i) & stat_w[bit_addr_i[2:0]];
        bit_hit_o   <= stat_bit_hit(bit_addr_i);
      end
    end
  end

  assign converter_mode_o  = mode_ff;
  assign pri_control_o     = ctl_ff[0];
  assign aux_control_o     = ctl_ff[1];
  assign sinc_decimation_o = sinc_ff;
  assign excitation_o      = exc_ff;
  assign start_pulse_o     = start_ff;

endmodule

`default_nettype wire

// file: dasb_bank_assertions.sv
// port checker of the dual converter register bank
// assumes: bound to dasb_bank; core accesses are one cycle wide
`timescale 1ns/10ps
`default_nettype none
module dasb_chk (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rst_b_i,
  // byte and bit access
  input wire logic [7:0] sfr_addr_i,
  input wire logic       sfr_wr_i,
  input wire logic       sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       sfr_hit_o,
  input wire logic [7:0] bit_addr_i,
  input wire logic       bit_rd_i,
  input wire logic       bit_rdata_o,
  input wire logic       ref_missing_i,
  // configuration
  input wire logic [7:0] converter_mode_o,
  input wire logic [7:0] sinc_decimation_o,
  input wire logic [7:0] excitation_o,
  input wire logic       start_pulse_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic mapped;
  assign mapped = sfr_addr_i inside {[8'hD1:8'hD5], 8'hD8, [8'hDA:8'hDD], [8'hE2:8'hE5], [8'hEA:8'hED]};
  a_unmapped_read : assert property (
    sfr_rd_i && !mapped |=> !sfr_hit_o && sfr_rdata_o == 8'hFF) else $error("unmapped read not FF");
  a_mode_write : assert property (
    sfr_wr_i && sfr_addr_i == 8'hD1 |=> converter_mode_o == $past(sfr_wdata_i)) else $error("mode lost");
  a_start_pulse : assert property (
    sfr_wr_i && sfr_addr_i == 8'hD1 && sfr_wdata_i[2:0] != 3'h0 |=> start_pulse_o) else $error("no start");
  a_bit_outside : assert property (
    bit_rd_i && bit_addr_i[7:3] != 5'h1B |=> !bit_rdata_o) else $error("bit read outside status");
  a_noref_bit : assert property (
    bit_rd_i && bit_addr_i == 8'hDC && ref_missing_i && converter_mode_o[5] |=> bit_rdata_o)
    else $error("missing reference not flagged");
  a_unmapped_write : assert property (
    sfr_wr_i && !mapped |=> $stable(converter_mode_o) && $stable(sinc_decimation_o) && $stable(excitation_o))
    else $error("unmapped write took effect");
  a_sinc_write : assert property (
    sfr_wr_i && sfr_addr_i == 8'hD4 |=> sinc_decimation_o == $past(sfr_wdata_i)) else $error("sinc lost");
  a_excite_write : assert property (
    sfr_wr_i && sfr_addr_i == 8'hD5 |=> excitation_o == $past(sfr_wdata_i)) else $error("excitation lost");
endmodule
bind dasb_bank dasb_chk u_chk (.*);
`default_nettype wire

// file: dasb_core_model.sv
// model of the core side of the byte register bus
// assumes: shares clk_i with the bank; one access at a time
`timescale 1ns/10ps
`default_nettype none
module dasb_core_model (
  // clock
  input  wire logic       clk_i,
  // byte access towards the bank
  output var  logic [7:0] sfr_addr_o,
  output var  logic       sfr_wr_o,
  output var  logic       sfr_rd_o,
  output var  logic [7:0] sfr_wdata_o,
  input  wire logic [7:0] sfr_rdata_i,
  input  wire logic       sfr_hit_i
);
  initial begin
    sfr_addr_o = 8'h00;
    sfr_wr_o = 1'b0;
    sfr_rd_o = 1'b0;
    sfr_wdata_o = 8'h00;
  end
  // held-back addresses come only from scenarios expecting a refusal
  // released lines show the inverse, so a stale value never looks live
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    sfr_addr_o <= a;
    sfr_wdata_o <= d;
    sfr_wr_o <= 1'b1;
    @(posedge clk_i);
    sfr_wr_o <= 1'b0;
    sfr_addr_o <= ~a;
    sfr_wdata_o <= ~d;
  endtask
  task automatic rd_byte(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(posedge clk_i);
    sfr_addr_o <= a;
    sfr_rd_o <= 1'b1;
    @(posedge clk_i);
    sfr_rd_o <= 1'b0;
    sfr_addr_o <= ~a;
    @(posedge clk_i);
    d = sfr_rdata_i;
    h = sfr_hit_i;
  endtask
endmodule
`default_nettype wire

// file: testbench.sv
// self-checking bench of the dual converter register bank
// assumes: core model owns the byte bus; bench drives bit bus, engines, reference
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [7:0]  sfr_addr_i, sfr_wdata_i, sfr_rdata_o, bit_addr_i = 8'h00;
  logic        sfr_wr_i, sfr_rd_i, sfr_hit_o, bit_rdata_o, bit_hit_o;
  logic        bit_wr_i = 1'b0, bit_rd_i = 1'b0, bit_wdata_i = 1'b0, ref_missing_i = 1'b0;
  logic [1:0]  done = 2'h0, clamp = 2'h0;
  logic [1:0]  kind [2] = '{2'h0, 2'h0};
  logic [15:0] edata [2] = '{16'h0000, 16'h0000};
  logic [15:0] wd;
  logic [7:0]  wv, rv, rv2, pctl, actl;
  logic        h, q;
  int          miscompares = 0, n_tests = 0, cyc = 0;
  integer      seed = 32'he736;
  logic [7:0]  amap [18] = '{8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD5, 8'hD8, 8'hDA, 8'hDB, 8'hDC, 8'hDD,
                             8'hE2, 8'hE3, 8'hE4, 8'hE5, 8'hEA, 8'hEB, 8'hEC, 8'hED};
  logic [7:0]  emap [18] = '{8'h00, 8'h00, 8'h00, 8'h45, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                             8'h00, 8'h80, 8'h00, 8'h80, 8'h55, 8'h53, 8'h9A, 8'h59};
  logic [7:0]  hole [4] = '{8'hD6, 8'hD9, 8'hDE, 8'hE1};
  logic [7:0]  pbase [2][3] = '{'{8'hDA, 8'hE2, 8'hEA}, '{8'hDC, 8'hE4, 8'hEC}};

  always #10 clk_i = ~clk_i;

  dasb_core_model core (.clk_i, .sfr_addr_o(sfr_addr_i), .sfr_wr_o(sfr_wr_i), .sfr_rd_o(sfr_rd_i),
    .sfr_wdata_o(sfr_wdata_i), .sfr_rdata_i(sfr_rdata_o), .sfr_hit_i(sfr_hit_o));
  dasb_bank dut (.clk_i, .rst_b_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .sfr_hit_o,
    .bit_addr_i, .bit_wr_i, .bit_rd_i, .bit_wdata_i, .bit_rdata_o, .bit_hit_o, .ref_missing_i,
    .pri_done_i(done[0]), .pri_kind_i(kind[0]), .pri_data_i(edata[0]), .pri_clamp_i(clamp[0]),
    .aux_done_i(done[1]), .aux_kind_i(kind[1]), .aux_data_i(edata[1]), .aux_clamp_i(clamp[1]),
    .converter_mode_o(), .pri_control_o(pctl), .aux_control_o(actl), .sinc_decimation_o(), .excitation_o(),
    .start_pulse_o());

  // result registers are read-only, so a write leaves the old value
  function automatic logic [7:0] after_wr(input logic [7:0] a, input logic [7:0] old, input logic [7:0] v);
    return (a inside {[8'hDA:8'hDD]}) ? old : v;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bit_op(input logic w, input logic [7:0] a, input logic d, output logic r);
    @(posedge clk_i);
    bit_addr_i <= a;
    bit_wr_i <= w;
    bit_rd_i <= !w;
    bit_wdata_i <= d;
    @(posedge clk_i);
    bit_wr_i <= 1'b0;
    bit_rd_i <= 1'b0;
    bit_addr_i <= ~a;
    @(posedge clk_i);
    r = bit_rdata_o;
  endtask
  task automatic fin(input int e, input logic [1:0] k, input logic [15:0] d, input logic c);
    @(posedge clk_i);
    done[e] <= 1'b1;
    kind[e] <= k;
    edata[e] <= d;
    clamp[e] <= c;
    @(posedge clk_i);
    done[e] <= 1'b0;
    edata[e] <= ~d;
    @(posedge clk_i);
  endtask
  task automatic end_sim;
    $display("Checks %0d, miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      miscompares++;
      end_sim;
    end
  end

  initial begin
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 18; i++) begin
      core.rd_byte(amap[i], rv, h);
      chk({h, rv}, {1'b1, emap[i]});
    end
    for (int i = 0; i < 18; i++) begin
      wv = $random(seed);
      if (i != 5) core.wr_byte(amap[i], wv);
      if (i != 5) emap[i] = after_wr(amap[i], emap[i], wv);
    end
    foreach (hole[j]) begin
      wv = $random(seed);
      core.wr_byte(hole[j], wv);
      core.rd_byte(hole[j], rv, h);
      chk({h, rv}, 9'h0FF);
    end
    for (int i = 0; i < 18; i++) begin
      core.rd_byte(amap[i], rv, h);
      chk(rv, emap[i]);
    end
    bit_op(1'b0, 8'hD0, 1'b0, q);
    chk(q, 1'b0);
    chk(bit_hit_o, 1'b0);
    chk({pctl, actl}, {emap[1], emap[2]});
    core.wr_byte(8'hD2, 8'h00);
    core.wr_byte(8'hD3, 8'h00);
    for (int e = 0; e < 2; e++)
      for (int k = 0; k < 3; k++) begin
        wd = $random(seed);
        if (k == 1) bit_op(1'b1, 8'hDF - e[7:0], 1'b0, q);
        else core.wr_byte(8'hD8, 8'h00);
        fin(e, k[1:0], wd, 1'b0);
        // a second completion while ready is still set must be dropped
        fin(e, k[1:0], ~wd, 1'b0);
        core.rd_byte(pbase[e][k], rv, h);
        core.rd_byte(pbase[e][k] + 8'h01, rv2, h);
        chk({rv2, rv}, wd);
        bit_op(1'b0, 8'hDF - e[7:0], 1'b0, q);
        chk(q, 1'b1);
        chk(bit_hit_o, 1'b1);
        bit_op(1'b0, 8'hDD, 1'b0, q);
        chk(q, e == 1 || k != 0);
      end
    core.wr_byte(8'hD8, 8'h00);
    fin(1, 2'h0, 16'h0000, 1'b1);
    bit_op(1'b0, 8'hDA, 1'b0, q);
    chk(q, 1'b1);
    core.wr_byte(8'hD1, 8'h11);
    bit_op(1'b0, 8'hDA, 1'b0, q);
    chk(q, 1'b0);
    ref_missing_i <= 1'b1;
    core.wr_byte(8'hD2, 8'h40);
    core.wr_byte(8'hD1, 8'h21);
    bit_op(1'b0, 8'hDC, 1'b0, q);
    chk(q, 1'b1);
    chk({pctl, actl}, 16'h4000);
    fin(0, 2'h0, wd, 1'b0);
    core.rd_byte(8'hDA, rv, h);
    core.rd_byte(8'hDB, rv2, h);
    chk({rv2, rv}, 16'hFFFF);
    bit_op(1'b0, 8'hDB, 1'b0, q);
    chk(q, 1'b1);
    end_sim;
  end
endmodule
`default_nettype wire
